// [core/ds3_alarm_pkg.sv]
// shared constants and carrier types for the ds3 receive alarm detector
// assumes one receive bit per clk_i cycle at most, marked by the framer datapath
package ds3_alarm_pkg;
  // information field and window sizes
  localparam logic [6:0] FIELD_BITS = 7'h54;
  localparam logic [10:0] WINDOW_FIELDS = 11'h400;
  localparam logic [2:0] FIELD_ERR_LIMIT = 3'h4;
  localparam logic [1:0] C_PER_SUBFRAME = 2'h3;
  localparam logic [1:0] C_MAJORITY = 2'h2;
  localparam logic [2:0] IDLE_C_SUBFRAME = 3'h3;
  // unframed all-ones
  localparam logic [12:0] FRAME_BITS = 13'h1298;
  localparam logic [2:0] UA1_ZERO_SAT = 3'h5;
  localparam logic [3:0] UA1_MAX_ZEROS = 4'h4;
  // loss of signal
  localparam logic [7:0] LOS_ZEROS = 8'hc0;
  localparam logic [7:0] LOS_WINDOW = 8'hc0;
  // framing supervision
  localparam logic [4:0] F_ERR_LIMIT = 5'h03;
  localparam logic [2:0] M_ERR_LIMIT = 3'h2;
  localparam logic [4:0] REFRAME_F_BITS = 5'h18;
  localparam logic [1:0] REFRAME_MFRAMES = 2'h2;
  localparam logic [2:0] RAI_MFRAMES = 3'h4;
  localparam int NUM_ALARMS = 7;

  // kind of the bit now on the stream
  typedef enum logic [2:0] {KIND_INFO, KIND_F, KIND_M, KIND_X, KIND_P, KIND_C} bit_kind_type;

  // one received bit with its position markers
  typedef struct packed {
    logic valid;
    logic data;
    bit_kind_type kind;
    logic field_start;
    logic mframe_end;
    logic [2:0] subframe;
    logic ovh_err;
    logic excessive_zeros_event;
  } rx_bit_type;

  // real-time indications
  typedef struct packed {
    logic ais;
    logic unframed_all_ones;
    logic los;
    logic oof;
    logic sef;
    logic rai;
    logic idle_signal_detected;
  } alarm_type;

  // loss of signal recovery states
  typedef enum logic [1:0] {LOS_CLEAR, LOS_WAIT, LOS_WINDOW_RUN} los_state_type;
endpackage

// [core/field_pattern_detector.sv]
// framed pattern detector over 84-bit information fields, with c-bit check
// assumes field_start marks the first information bit after each overhead bit
`timescale 1ns/1ps
module field_pattern_detector
  import ds3_alarm_pkg::*;
#(
  parameter int PHASE_SEL = 0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // receive stream
  input wire rx_bit_type rx_i,
  input wire logic c_use_i,
  input wire logic restart_i,
  // indication
  output logic active_o
);
  logic [6:0] pos;
  logic [1:0] phase;
  logic [2:0] errs;
  logic aligned;
  logic [10:0] good_run;
  logic [10:0] bad_run;
  logic [1:0] c_idx;
  logic [1:0] c_ones;
  logic info;
  logic miss;
  logic field_done;
  logic field_good;
  logic c_bit;
  logic c_spoil;
  logic [6:0] cur_pos;
  logic [1:0] cur_phase;
  logic [2:0] cur_err;
  logic [2:0] next_err;

  // expected bit is the inverse of the selected phase bit
  always_comb begin
    info = rx_i.valid && rx_i.kind == KIND_INFO;
    cur_pos = rx_i.field_start ? 7'h00 : pos;
    cur_phase = rx_i.field_start ? 2'h0 : phase;
    cur_err = rx_i.field_start ? 3'h0 : errs;
    miss = rx_i.data == cur_phase[PHASE_SEL];
    next_err = (cur_err == FIELD_ERR_LIMIT) ? cur_err : cur_err + {2'h0, miss};
    field_done = info && (aligned || rx_i.field_start) && cur_pos == FIELD_BITS - 7'h01;
    field_good = next_err < FIELD_ERR_LIMIT;
    c_bit = rx_i.valid && rx_i.kind == KIND_C && c_use_i;
    c_spoil = c_bit && c_idx == C_PER_SUBFRAME - 2'h1
              && (c_ones + {1'b0, rx_i.data}) >= C_MAJORITY;
  end

  // position and error count inside the field; pattern restarts per field
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos <= 7'h00;
      phase <= 2'h0;
      errs <= 3'h0;
      aligned <= 1'b0;
    end else if (restart_i) begin
      aligned <= 1'b0;
    end else if (info) begin
      pos <= cur_pos + 7'h01;
      phase <= cur_phase + 2'h1;
      errs <= next_err;
      if (rx_i.field_start) begin
        aligned <= 1'b1;
      end else if (field_done) begin
        aligned <= 1'b0; // a field counts once; stray bits cannot wrap pos into a new one
      end
    end
  end

  // c bits are majority decoded in groups of three
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      c_idx <= 2'h0;
      c_ones <= 2'h0;
    end else if (rx_i.valid && rx_i.mframe_end) begin
      c_idx <= 2'h0;
      c_ones <= 2'h0;
    end else if (c_bit) begin
      if (c_idx == C_PER_SUBFRAME - 2'h1) begin
        c_idx <= 2'h0;
        c_ones <= 2'h0;
      end else begin
        c_idx <= c_idx + 2'h1;
        c_ones <= c_ones + {1'b0, rx_i.data};
      end
    end
  end

  // consecutive good and bad field runs, saturating one short of the window
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      good_run <= 11'h000;
      bad_run <= 11'h000;
    end else if (restart_i) begin
      good_run <= 11'h000;
      bad_run <= 11'h000;
    end else if (field_done) begin
      if (field_good) begin
        bad_run <= 11'h000;
        if (good_run != WINDOW_FIELDS - 11'h001) begin
          good_run <= good_run + 11'h001;
        end
      end else begin
        good_run <= 11'h000;
        if (bad_run != WINDOW_FIELDS - 11'h001) begin
          bad_run <= bad_run + 11'h001;
        end
      end
    end else if (c_spoil) begin
      good_run <= 11'h000;
    end
  end

  // indication itself; held while the runs restart after a framing loss
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
    end else if (field_done && !restart_i) begin
      // a field that ends as alignment is lost must not count
      if (field_good && good_run == WINDOW_FIELDS - 11'h001) begin
        active_o <= 1'b1;
      end else if (!field_good && bad_run == WINDOW_FIELDS - 11'h001) begin
        active_o <= 1'b0;
      end
    end
  end

  property p_field_set;
    @(posedge clk_i) disable iff (rst_i)
    $rose(active_o) |-> $past(good_run) == WINDOW_FIELDS - 11'h001 && $past(field_good);
  endproperty
  a_field_set: assert property (p_field_set) else $error("pattern set too early");

  property p_field_clr;
    @(posedge clk_i) disable iff (rst_i)
    $fell(active_o) |-> $past(bad_run) == WINDOW_FIELDS - 11'h001 && !$past(field_good);
  endproperty
  a_field_clr: assert property (p_field_clr) else $error("pattern clear too early");
endmodule

// [core/alarm_change_detector.sv]
// both-edge change detector over the real-time indications
// assumes the indications come straight from flip-flops
`timescale 1ns/1ps
module alarm_change_detector
  import ds3_alarm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // indications
  input wire logic [NUM_ALARMS-1:0] alarm_i,
  // change pulses
  output logic [NUM_ALARMS-1:0] change_o
);
  logic [NUM_ALARMS-1:0] prev;

  // one delay flop and one pulse flop per indication
  genvar k;
  generate
    for (k = 0; k < NUM_ALARMS; k = k + 1) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          prev[k] <= 1'b0;
          change_o[k] <= 1'b0;
        end else begin
          prev[k] <= alarm_i[k];
          change_o[k] <= alarm_i[k] ^ prev[k];
        end
      end
    end
  endgenerate

  property p_change;
    @(posedge clk_i) disable iff (rst_i)
    (alarm_i != prev) |=> (change_o == ($past(alarm_i) ^ $past(prev))) && change_o != 0;
  endproperty
  a_change: assert property (p_change) else $error("change pulse missing");

  property p_quiet;
    @(posedge clk_i) disable iff (rst_i)
    (alarm_i == prev) |=> change_o == 0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("spurious change pulse");
endmodule

// [core/ds3_receive_alarm_detector.sv]
// receive alarm and defect detector for one ds3 channel
// assumes the framer marks each bit's kind and position and flags f/m errors
//
// Overview of operation
// - alarm pattern is framed 1010, restarting with a one after overhead
// - alarm set after 1024 consecutive fields each under four pattern errors
// - alarm also needs every c bit group decoding to zero meanwhile
// - alarm cleared after 1024 consecutive fields with four or more errors
// - all-ones set when two consecutive frames hold at most four zeros
// - all-ones cleared when two consecutive frames hold five or more zeros
// - loss set after 192 zeros; cleared by a clean 192-bit window
// - out-of-frame on 3 of 16 f bits or 2 of 4 m bits errored
// - reframe needs 24 good f bits then two clean m-frames
// - severe frame error set on 3 of 16 f bits errored
// - severe frame error cleared only in sync with under three errors
// - remote alarm set when both x bits are zero four m-frames running
// - remote alarm cleared when both x bits are one four m-frames running
// - idle pattern is framed 1100, restarting with two ones after overhead
// - idle set after 1024 consecutive fields each under four errors
// - idle also needs subframe three c bits decoding to zero meanwhile
// - idle cleared after 1024 consecutive fields with four or more errors
// - every indication edge, rising or falling, gives one change pulse
`timescale 1ns/1ps
module ds3_receive_alarm_detector
  import ds3_alarm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // decoded receive stream with framer markers
  input wire rx_bit_type rx_i,
  // real-time indications
  output alarm_type alarm_o,
  // change events to the latched status logic
  output logic [NUM_ALARMS-1:0] change_o
);
  logic ais;
  logic idle;
  logic ua1;
  logic los;
  logic oof;
  logic sef;
  logic rai;
  logic bit_in;
  logic zero_in;
  logic f_bit;
  logic m_bit;
  logic mf_end;
  logic idle_c_use;

  // bit qualifiers shared by the detectors here; without a bit only the out-of-frame resets and the sef clear act
  always_comb begin
    bit_in = rx_i.valid;
    zero_in = rx_i.valid && !rx_i.data;
    f_bit = rx_i.valid && rx_i.kind == KIND_F;
    m_bit = rx_i.valid && rx_i.kind == KIND_M;
    mf_end = rx_i.valid && rx_i.mframe_end;
    idle_c_use = rx_i.subframe == IDLE_C_SUBFRAME;
  end

  // framed pattern detectors, restarted while out of frame
  field_pattern_detector #(
    .PHASE_SEL(0)
  ) u_ais_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx_i(rx_i),
    .c_use_i(1'b1),
    .restart_i(oof),
    .active_o(ais)
  );

  field_pattern_detector #(
    .PHASE_SEL(1)
  ) u_idle_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx_i(rx_i),
    .c_use_i(idle_c_use),
    .restart_i(oof),
    .active_o(idle)
  );

  // unframed all-ones over sliding pairs of 4760-bit blocks
  logic [12:0] blk_pos;
  logic [2:0] zc;
  logic [2:0] zprev;
  logic [2:0] cur_zc;
  logic [3:0] pair_zeros;
  logic blk_end;

  always_comb begin
    cur_zc = (zc == UA1_ZERO_SAT) ? zc : zc + {2'h0, zero_in};
    pair_zeros = {1'b0, zprev} + {1'b0, cur_zc};
    blk_end = bit_in && blk_pos == FRAME_BITS - 13'h0001;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      blk_pos <= 13'h0000;
      zc <= 3'h0;
      zprev <= UA1_ZERO_SAT; // counts as noisy until a full pair is seen
      ua1 <= 1'b0;
    end else if (blk_end) begin
      blk_pos <= 13'h0000;
      zc <= 3'h0;
      zprev <= cur_zc;
      ua1 <= pair_zeros <= UA1_MAX_ZEROS;
    end else if (bit_in) begin
      blk_pos <= blk_pos + 13'h0001;
      zc <= cur_zc;
    end
  end

  // loss of signal; recovery window aborts on an excessive-zero event
  los_state_type los_state;
  logic [7:0] zrun;
  logic [7:0] win_cnt;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zrun <= 8'h00;
    end else if (bit_in) begin
      if (rx_i.data) begin
        zrun <= 8'h00;
      end else if (zrun != LOS_ZEROS) begin
        zrun <= zrun + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      los_state <= LOS_CLEAR;
      win_cnt <= 8'h00;
    end else if (bit_in) begin
      case (los_state)
        LOS_CLEAR: begin
          if (zero_in && zrun == LOS_ZEROS - 8'h01) begin
            los_state <= LOS_WAIT;
          end
        end
        LOS_WAIT: begin
          if (rx_i.data) begin
            los_state <= LOS_WINDOW_RUN;
            win_cnt <= 8'h01;
          end
        end
        LOS_WINDOW_RUN: begin
          if (rx_i.excessive_zeros_event) begin
            los_state <= LOS_WAIT;
          end else if (win_cnt == LOS_WINDOW - 8'h01) begin
            los_state <= LOS_CLEAR;
          end else begin
            win_cnt <= win_cnt + 8'h01;
          end
        end
        default: begin
          los_state <= LOS_CLEAR;
        end
      endcase
    end
  end

  always_comb begin
    los = los_state != LOS_CLEAR;
  end

  // sliding error histories of f and m bits
  logic [15:0] f_hist;
  logic [3:0] m_hist;
  logic [15:0] next_f_hist;
  logic [3:0] next_m_hist;
  logic [4:0] f_cnt;
  logic [4:0] next_f_cnt;
  logic [2:0] next_m_cnt;
  logic reframe_done;

  always_comb begin
    next_f_hist = f_bit ? {f_hist[14:0], rx_i.ovh_err} : f_hist;
    next_m_hist = m_bit ? {m_hist[2:0], rx_i.ovh_err} : m_hist;
    f_cnt = 5'($countones(f_hist));
    next_f_cnt = 5'($countones(next_f_hist));
    next_m_cnt = 3'($countones(next_m_hist));
  end

  // histories restart on reframe so old errors cannot re-declare at once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      f_hist <= 16'h0000;
      m_hist <= 4'h0;
    end else if (reframe_done) begin
      f_hist <= 16'h0000;
      m_hist <= 4'h0;
    end else begin
      f_hist <= next_f_hist;
      m_hist <= next_m_hist;
    end
  end

  // per m-frame overhead capture: x and p pairs, m error seen
  logic [1:0] xs;
  logic [1:0] ps;
  logic m_err_seen;
  logic mf_clean;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xs <= 2'h0;
      ps <= 2'h0;
      m_err_seen <= 1'b0;
    end else if (mf_end) begin
      m_err_seen <= 1'b0;
    end else begin
      if (rx_i.valid && rx_i.kind == KIND_X) begin
        xs <= {xs[0], rx_i.data};
      end
      if (rx_i.valid && rx_i.kind == KIND_P) begin
        ps <= {ps[0], rx_i.data};
      end
      if (m_bit && rx_i.ovh_err) begin
        m_err_seen <= 1'b1;
      end
    end
  end

  always_comb begin
    mf_clean = !m_err_seen && xs[0] == xs[1] && ps[0] == ps[1];
  end

  // reframe qualification: good f run, then clean m-frames that start after it
  logic [4:0] f_good;
  logic armed;
  logic [1:0] mf_good;

  always_comb begin
    reframe_done = oof && mf_end && armed && mf_clean
                   && mf_good == REFRAME_MFRAMES - 2'h1;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      f_good <= 5'h00;
      armed <= 1'b0;
      mf_good <= 2'h0;
    end else if (!oof) begin
      f_good <= 5'h00;
      armed <= 1'b0;
      mf_good <= 2'h0;
    end else if (f_bit && rx_i.ovh_err) begin
      f_good <= 5'h00;
      armed <= 1'b0;
      mf_good <= 2'h0;
    end else if (f_bit && f_good != REFRAME_F_BITS) begin
      f_good <= f_good + 5'h01;
    end else if (mf_end) begin
      if (armed) begin
        mf_good <= mf_clean ? mf_good + 2'h1 : 2'h0;
      end
      armed <= f_good == REFRAME_F_BITS;
    end
  end

  // out-of-frame and severely errored frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oof <= 1'b0;
    end else if (!oof) begin
      if (next_f_cnt >= F_ERR_LIMIT || next_m_cnt >= M_ERR_LIMIT) begin
        oof <= 1'b1;
      end
    end else if (reframe_done) begin
      oof <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sef <= 1'b0;
    end else if (next_f_cnt >= F_ERR_LIMIT) begin
      sef <= 1'b1;
    end else if (!oof) begin
      sef <= 1'b0;
    end
  end

  // remote alarm from both x bits over consecutive m-frames
  logic [2:0] rai_zero_run;
  logic [2:0] rai_one_run;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rai_zero_run <= 3'h0;
      rai_one_run <= 3'h0;
      rai <= 1'b0;
    end else if (mf_end) begin
      if (xs == 2'h0) begin
        rai_one_run <= 3'h0;
        if (rai_zero_run != RAI_MFRAMES) begin
          rai_zero_run <= rai_zero_run + 3'h1;
        end
        if (rai_zero_run == RAI_MFRAMES - 3'h1) begin
          rai <= 1'b1;
        end
      end else if (xs == 2'h3) begin
        rai_zero_run <= 3'h0;
        if (rai_one_run != RAI_MFRAMES) begin
          rai_one_run <= rai_one_run + 3'h1;
        end
        if (rai_one_run == RAI_MFRAMES - 3'h1) begin
          rai <= 1'b0;
        end
      end else begin
        rai_zero_run <= 3'h0;
        rai_one_run <= 3'h0;
      end
    end
  end

  // indication outputs, all straight from flip-flops except los, decoded from los_state
  always_comb begin
    alarm_o.ais = ais;
    alarm_o.unframed_all_ones = ua1;
    alarm_o.los = los;
    alarm_o.oof = oof;
    alarm_o.sef = sef;
    alarm_o.rai = rai;
    alarm_o.idle_signal_detected = idle;
  end

  alarm_change_detector u_change (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .alarm_i(alarm_o),
    .change_o(change_o)
  );

  property p_los_set;
    @(posedge clk_i) disable iff (rst_i)
    (los_state == LOS_CLEAR && zero_in && zrun == LOS_ZEROS - 8'h01) |=> los;
  endproperty
  a_los_set: assert property (p_los_set) else $error("loss not set after zero run");

  property p_los_clr;
    @(posedge clk_i) disable iff (rst_i)
    $fell(los) |-> $past(win_cnt) == LOS_WINDOW - 8'h01 && !$past(rx_i.excessive_zeros_event);
  endproperty
  a_los_clr: assert property (p_los_clr) else $error("loss cleared without window");

  property p_ua1_set;
    @(posedge clk_i) disable iff (rst_i)
    (blk_end && pair_zeros <= UA1_MAX_ZEROS) |=> ua1;
  endproperty
  a_ua1_set: assert property (p_ua1_set) else $error("all-ones not set");

  property p_ua1_clr;
    @(posedge clk_i) disable iff (rst_i)
    (blk_end && pair_zeros > UA1_MAX_ZEROS) |=> !ua1;
  endproperty
  a_ua1_clr: assert property (p_ua1_clr) else $error("all-ones not cleared");

  property p_f_window;
    @(posedge clk_i) disable iff (rst_i)
    f_cnt >= F_ERR_LIMIT |-> oof && sef;
  endproperty
  a_f_window: assert property (p_f_window) else $error("f errors not flagged");

  property p_m_window;
    @(posedge clk_i) disable iff (rst_i)
    (!oof && next_m_cnt >= M_ERR_LIMIT) |=> oof;
  endproperty
  a_m_window: assert property (p_m_window) else $error("m errors not flagged");

  property p_reframe;
    @(posedge clk_i) disable iff (rst_i)
    $fell(oof) |-> $past(f_good) == REFRAME_F_BITS && $past(mf_good) == 2'h1;
  endproperty
  a_reframe: assert property (p_reframe) else $error("reframe too early");

  property p_sef_clr;
    @(posedge clk_i) disable iff (rst_i)
    $fell(sef) |-> !$past(oof) && $past(next_f_cnt) < F_ERR_LIMIT;
  endproperty
  a_sef_clr: assert property (p_sef_clr) else $error("sef cleared out of sync");

  property p_rai_set;
    @(posedge clk_i) disable iff (rst_i)
    $rose(rai) |-> $past(rai_zero_run) == RAI_MFRAMES - 3'h1 && $past(xs) == 2'h0;
  endproperty
  a_rai_set: assert property (p_rai_set) else $error("remote alarm set early");

  property p_rai_clr;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rai) |-> $past(rai_one_run) == RAI_MFRAMES - 3'h1 && $past(xs) == 2'h3;
  endproperty
  a_rai_clr: assert property (p_rai_clr) else $error("remote alarm cleared early");
endmodule

// [tb/line_source.sv]
// line-side source model feeding received bits to the alarm detector
// assumes the bench changes send_i and bit_i just after the falling clock edge
`timescale 1ns/1ps
module line_source
  import ds3_alarm_pkg::*;
(
  // clock
  input wire logic clk_i,
  // bit offered by the bench
  input wire logic send_i,
  input wire rx_bit_type bit_i,
  // stream into the detector
  output rx_bit_type rx_o
);
  logic junk = 1'h0;

  // idle content flips every cycle so a stale bit never looks valid
  always @(posedge clk_i) begin
    junk <= ~junk;
  end

  // between bits the line shows no usable value
  assign rx_o = send_i ? bit_i : rx_bit_type'({1'h0, {11{junk}}});
endmodule

// [tb/testbench.sv]
// self-checking bench for the ds3 receive alarm detector
// assumes one bit per cycle at most, driven on the falling edge
`timescale 1ns/1ps
module testbench
  import ds3_alarm_pkg::*;
;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic send = 1'h0;
  rx_bit_type req = '0;
  rx_bit_type rx;
  alarm_type alarm;
  logic [6:0] change;
  int errors = 0;
  int total_checks = 0;
  int seed = 25;
  // reference model state
  int zrun, win, zc, zp, nb, xz, xo, fgood, arm, fe, me;
  int fq[$];
  int mq[$];
  int fpos, ferr, good, bad, algn, ci, cq;
  logic xa, xb, pa, pb, merr, los, ua, rai, oof, sef, ais;
  logic [6:0] a0, a1, a2;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  line_source src (.clk_i(clk_i), .send_i(send), .bit_i(req), .rx_o(rx));
  ds3_receive_alarm_detector dut (.clk_i(clk_i), .rst_i(rst_i), .rx_i(rx), .alarm_o(alarm),
    .change_o(change));

  task automatic compare(input string what, input logic [6:0] seen, input logic [6:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic rx_bit_type mk(input logic d, input bit_kind_type k, input logic e,
                                    input logic fin, input logic z);
    return {1'h1, d, k, 1'h0, fin, 3'h1, e, z};
  endfunction

  // compare last result, offer the next bit, then advance the model
  task automatic step(input rx_bit_type b);
    logic old;
    @(negedge clk_i);
    compare("alarm", alarm, a0);
    compare("change", change, a1 ^ a2);
    req = b;
    send = b.valid;
    old = oof;
    if (b.valid) begin
      // framed 1010 fields, restarted while out of frame; a c triple voting one spoils the run
      if (old) begin
        {good, bad, algn} = '0;
      end else if (b.kind == KIND_INFO && (algn > 0 || b.field_start)) begin
        if (b.field_start) {fpos, ferr} = '0;
        algn = 1;
        ferr += (b.data != (fpos % 2 == 0));
        fpos++;
        if (fpos == 84) begin
          good = (ferr < 4) ? good + 1 : 0;
          bad = (ferr < 4) ? 0 : bad + 1;
          ais = (good >= 1024) ? 1'h1 : (bad >= 1024) ? 1'h0 : ais;
        end
      end
      if (b.kind == KIND_C) begin
        cq += b.data;
        ci++;
        if (ci == 3) begin
          if (cq >= 2) good = 0;
          {ci, cq} = '0;
        end
      end
      if (b.mframe_end) {ci, cq} = '0;
      zrun = b.data ? 0 : zrun + 1;
      if (!los) los = (zrun >= 192);
      else if (win > 0) win = b.excessive_zeros_event ? 0 : win + 1;
      else if (b.data) win = 1;
      if (win == 192) begin
        los = 1'h0;
        win = 0;
      end
      // all-ones blocks counted from reset
      zc += !b.data;
      nb++;
      if (nb == 4760) begin
        ua = (zp + zc <= 4);
        zp = zc;
        zc = 0;
        nb = 0;
      end
      if (b.kind == KIND_X) {xa, xb} = {xb, b.data};
      if (b.kind == KIND_P) {pa, pb} = {pb, b.data};
      if (b.kind == KIND_F) fq.push_back(b.ovh_err);
      if (b.kind == KIND_F) fgood = b.ovh_err ? 0 : fgood + 1;
      if (b.kind == KIND_M) mq.push_back(b.ovh_err);
      merr |= (b.kind == KIND_M) && b.ovh_err;
      if (fq.size() > 16) fq.pop_front();
      if (mq.size() > 4) mq.pop_front();
      fe = fq.sum();
      me = mq.sum();
      // out-of-frame entry and reframe sequence
      if (!oof && (fe >= 3 || me >= 2)) begin
        oof = 1'h1;
        arm = 0;
      end else if (oof && b.mframe_end) begin
        if (arm > 0) arm = (!merr && xa == xb && pa == pb) ? arm + 1 : 1;
        else if (fgood >= 24) arm = 1;
        if (arm == 3) begin
          oof = 1'h0;
          fq.delete();
          mq.delete();
          fe = 0;
          fgood = 0;
        end
      end
      if (b.mframe_end) begin
        xz = (!xa && !xb) ? xz + 1 : 0;
        xo = (xa && xb) ? xo + 1 : 0;
        rai = (xz >= 4) ? 1'h1 : (xo >= 4) ? 1'h0 : rai;
        merr = 1'h0;
      end
    end
    // severe frame error clears only a cycle after sync returns
    sef = (fe >= 3) ? 1'h1 : (old ? sef : 1'h0);
    a2 = a1;
    a1 = a0;
    a0 = {ais, ua, los, oof, sef, rai, 1'h0};
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    rst_i = 1'h1;
    send = 1'h0;
    {zrun, win, zc, nb, xz, xo, fgood, arm, fe, me} = '0;
    {fpos, ferr, good, bad, algn, ci, cq} = '0;
    {xa, xb, pa, pb, merr, los, ua, rai, oof, sef, ais} = '0;
    {a0, a1, a2} = '0;
    zp = 5;
    fq.delete();
    mq.delete();
    repeat (2) @(negedge clk_i);
    compare("alarm in reset", alarm, '0);
    compare("change in reset", change, '0);
    rst_i = 1'h0;
  endtask

  task automatic bits(input int n, input logic d, input logic rnd);
    repeat (n) step(mk(rnd ? 1'($random(seed)) : d, KIND_INFO, 1'h0, 1'h0,
                       rnd ? 1'($random(seed)) : 1'h0));
  endtask

  task automatic frame(input int nf, input logic x, input logic m);
    repeat (nf) step(mk(1'h1, KIND_F, 1'h0, 1'h0, 1'h0));
    step(mk(1'h1, KIND_M, m, 1'h0, 1'h0));
    repeat (2) step(mk(x, KIND_X, 1'h0, 1'h0, 1'h0));
    repeat (2) step(mk(1'h1, KIND_P, 1'h0, 1'h0, 1'h0));
    step(mk(1'h1, KIND_INFO, 1'h0, 1'h1, 1'h0));
  endtask

  // framed 1010 fields split by c bits, with rare random pattern errors
  task automatic ais_fields(input int n);
    rx_bit_type b;
    for (int f = 0; f < n; f++) begin
      for (int i = 0; i < 84; i++) begin
        b = mk(!i[0] ^ (($random(seed) & 32'h0000_03ff) == 0), KIND_INFO, 1'h0, 1'h0, 1'h0);
        b.field_start = (i == 0);
        step(b);
      end
      // the first c triple votes one, so the good run restarts after field 2
      step(mk(f < 3, KIND_C, 1'h0, 1'h0, 1'h0));
    end
  endtask

  // main sequence; a gap cycle checks that counters hold without bits
  initial begin
    do_reset();
    bits(191, 1'h0, 1'h0);
    step('0);
    bits(1, 1'h0, 1'h0);
    bits(50, 1'h1, 1'h0);
    step(mk(1'h0, KIND_INFO, 1'h0, 1'h0, 1'h1));
    bits(191, 1'h1, 1'h0);
    step('0);
    bits(1, 1'h1, 1'h0);
    // all-ones set on two clean blocks from reset, cleared by the alarm pattern
    do_reset();
    bits(2 * 4760, 1'h1, 1'h0);
    ais_fields(1027);
    bits(64, 1'h0, 1'h1);
    repeat (4) frame(4, 1'h0, 1'h0);
    repeat (4) frame(4, 1'h1, 1'h0);
    // three errored f bits, then reframe through clean m-frames
    repeat (3) begin
      step(mk(1'h1, KIND_F, 1'h1, 1'h0, 1'h0));
      bits(5, 1'h1, 1'h0);
    end
    repeat (5) frame(8, 1'h1, 1'h0);
    bits(4, 1'h1, 1'h0);
    // m-bit path, then a reset while out of frame
    step(mk(1'h1, KIND_F, 1'h1, 1'h0, 1'h0));
    repeat (2) step(mk(1'h1, KIND_M, 1'h1, 1'h0, 1'h0));
    bits(8, 1'h1, 1'h0);
    do_reset();
    bits(10, 1'h1, 1'h0);
    complete_run();
  end

  // hang guard
  initial begin
    #2500000;
    errors++;
    complete_run();
  end
endmodule
